// File: hdl/wdt_pkg.sv
// Constants and register layout for the watchdog timer block
package wdt_pkg;
    localparam logic [7:0] WDT_CTRL_ADDR = 8'hE1;
    localparam logic [7:0] WDT_CTRL_RESET = 8'h07;
    localparam int WDT_BIT_FLAG = 7;
    localparam int WDT_BIT_RSVD = 6;
    localparam int WDT_BIT_EN = 5;
    localparam int WDT_BIT_CLR = 4;
    localparam int WDT_BIT_IDLE = 3;
    localparam int WDT_PS_MSB = 2;
    localparam int WDT_PS_LSB = 0;
    localparam int WDT_CNT_WIDTH = 15;
    localparam int WDT_PRE_WIDTH = 8;
    localparam int WDT_PS_WIDTH = 3;
    localparam int WDT_BASE_DIV = 12;
endpackage

// File: hdl/wdt_divider.sv
// Divide-by-N enable pulse generator
`timescale 1ns/1ps
`default_nettype none
module wdt_divider #(
    parameter int DIV = 12
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic run,
    output logic tick
);
    localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);
    logic [CW-1:0] cnt_ff;
    logic [CW-1:0] nxt_cnt;

    initial begin
        if (DIV < 2) begin
            $error("wdt_divider: DIV must be at least 2");
        end
    end

    // Wrap at the last count while running
    assign tick = run && (cnt_ff == LAST);
    assign nxt_cnt = !run ? cnt_ff : (tick ? '0 : cnt_ff + CW'(1));

    // Count register
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end
endmodule
`default_nettype wire

// File: hdl/wdt_top.sv
// Watchdog timer with one-time enable and option write lock
`timescale 1ns/1ps
`default_nettype none
module wdt_top
    import wdt_pkg::*;
#(
    parameter int CNT_WIDTH = WDT_CNT_WIDTH,
    parameter int PRE_WIDTH = WDT_PRE_WIDTH,
    parameter int BASE_DIV = WDT_BASE_DIV
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    output logic [7:0] sfr_rdata,
    output logic sfr_sel,
    input wire logic cpu_idle,
    input wire logic option_auto_enable,
    input wire logic option_idle_count,
    input wire logic [WDT_PS_WIDTH-1:0] option_prescale_code,
    input wire logic option_write_protect,
    input wire logic option_always_count_idle,
    output logic watchdog_reset,
    output logic watchdog_running
);
    initial begin
        if (CNT_WIDTH < 2 || PRE_WIDTH != (1 << WDT_PS_WIDTH)) begin
            $error("wdt_top: unsupported counter or prescaler width");
        end
    end

    // Power-on reset is the only reset of this block
    // Options and idle come from the same clock domain as fuse latches

    logic watchdog_reset_flag_ff;
    logic watchdog_enable_once_ff;
    logic idle_count_enable_ff;
    logic [WDT_PS_WIDTH-1:0] prescale_select_ff;
    logic load_done_ff;
    logic lock_ff;
    logic [PRE_WIDTH-1:0] pre_ff;
    logic [CNT_WIDTH-1:0] cnt_ff;
    logic reset_ff;

    logic nxt_flag;
    logic nxt_enable;
    logic nxt_idle;
    logic [WDT_PS_WIDTH-1:0] nxt_ps;
    logic [PRE_WIDTH-1:0] nxt_pre;
    logic [CNT_WIDTH-1:0] nxt_cnt;

    wire hit = (sfr_addr == WDT_CTRL_ADDR);
    wire wr_hit = sfr_wr && hit && load_done_ff;
    wire clr_req = wr_hit && sfr_wdata[WDT_BIT_CLR];
    wire wr_free = wr_hit && !lock_ff;
    wire base_tick;
    wire pre_tick;
    wire cnt_wrap;
    wire may_count;
    wire [PRE_WIDTH-1:0] pre_mask;

    // Bus decode and read data
    assign sfr_sel = hit && (sfr_wr || sfr_rd);
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sfr_rdata <= '0;
        end else if (sfr_rd && hit) begin
            sfr_rdata <= {watchdog_reset_flag_ff, 1'b0,
                          watchdog_enable_once_ff, 1'b0,
                          idle_count_enable_ff, prescale_select_ff};
        end else begin
            sfr_rdata <= '0;
        end
    end

    // Counting allowed when enabled and idle permits
    assign may_count = watchdog_enable_once_ff &&
        (!cpu_idle || idle_count_enable_ff ||
         option_always_count_idle);
    assign watchdog_running = watchdog_enable_once_ff;

    // Divide by twelve base tick; frozen if clock stops
    wdt_divider #(
        .DIV(BASE_DIV)
    ) u_base_div (
        .clk(clk),
        .reset_n(reset_n),
        .run(may_count),
        .tick(base_tick)
    );

    // Prescaler: select 2^(code+1) using low bits mask
    assign pre_mask = PRE_WIDTH'((9'h002 << prescale_select_ff) - 9'h001);
    assign pre_tick = base_tick && ((pre_ff & pre_mask) == pre_mask);
    assign nxt_pre = base_tick ? pre_ff + PRE_WIDTH'(1) : pre_ff;

    // Main counter, wraps from all ones
    assign cnt_wrap = pre_tick && (&cnt_ff);
    always_comb begin
        nxt_cnt = cnt_ff;
        if (clr_req) begin
            nxt_cnt = '0;
        end else if (pre_tick) begin
            nxt_cnt = cnt_ff + CNT_WIDTH'(1);
        end
    end

    // Control field next values
    always_comb begin
        nxt_flag = watchdog_reset_flag_ff;
        nxt_enable = watchdog_enable_once_ff;
        nxt_idle = idle_count_enable_ff;
        nxt_ps = prescale_select_ff;
        if (!load_done_ff) begin
            if (option_auto_enable) begin
                nxt_enable = 1'b1;
                nxt_idle = option_idle_count;
                nxt_ps = option_prescale_code;
            end
        end else if (wr_free) begin
            // Bit six ignored, software keeps it zero
            nxt_flag = sfr_wdata[WDT_BIT_FLAG] &&
                       watchdog_reset_flag_ff;
            nxt_enable = watchdog_enable_once_ff ||
                         sfr_wdata[WDT_BIT_EN];
            nxt_idle = sfr_wdata[WDT_BIT_IDLE];
            nxt_ps = sfr_wdata[WDT_PS_MSB:WDT_PS_LSB];
        end
        if (cnt_wrap) begin
            nxt_flag = 1'b1;
        end
    end

    // Power-on value of the register
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            watchdog_reset_flag_ff <= WDT_CTRL_RESET[WDT_BIT_FLAG];
            watchdog_enable_once_ff <= WDT_CTRL_RESET[WDT_BIT_EN];
            idle_count_enable_ff <= WDT_CTRL_RESET[WDT_BIT_IDLE];
            prescale_select_ff <= WDT_CTRL_RESET[WDT_PS_MSB:WDT_PS_LSB];
        end else begin
            watchdog_reset_flag_ff <= nxt_flag;
            watchdog_enable_once_ff <= nxt_enable;
            idle_count_enable_ff <= nxt_idle;
            prescale_select_ff <= nxt_ps;
        end
    end

    // Option capture after release, write lock latched
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            load_done_ff <= 1'b0;
            lock_ff <= 1'b0;
        end else if (!load_done_ff) begin
            load_done_ff <= 1'b1;
            lock_ff <= option_auto_enable && option_write_protect;
        end
    end

    // Counters and reset pulse
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pre_ff <= '0;
            cnt_ff <= '0;
            reset_ff <= 1'b0;
        end else begin
            pre_ff <= clr_req ? '0 : nxt_pre;
            cnt_ff <= nxt_cnt;
            reset_ff <= cnt_wrap;
        end
    end

    // One-cycle system reset request
    assign watchdog_reset = reset_ff;
endmodule
`default_nettype wire

// File: bench/wdt_top_props.sv
// Port assertions for the watchdog timer
`timescale 1ns/1ps
`default_nettype none
module wdt_top_props (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_rdata,
    input wire logic sfr_sel,
    input wire logic option_auto_enable,
    input wire logic watchdog_reset,
    input wire logic watchdog_running
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // Bus side relations
    sel_decode_a: assert property (sfr_sel ==
        (sfr_addr == 8'hE1 && (sfr_rd || sfr_wr))) else $error("bad select");
    rdata_idle_a: assert property (!$past(sfr_rd && sfr_sel)
        |-> sfr_rdata == 8'h00) else $error("stray read data");
    fixed_zero_a: assert property (!sfr_rdata[6] && !sfr_rdata[4])
        else $error("bit six or four read as one");
    // Enable and overflow relations
    run_sticky_a: assert property (watchdog_running |=> watchdog_running)
        else $error("enable dropped");
    run_cause_a: assert property ($rose(watchdog_running) |->
        $past(option_auto_enable) || $past(sfr_wr && sfr_sel && sfr_wdata[5]))
        else $error("enable without cause");
    pulse_one_a: assert property (watchdog_reset |=> !watchdog_reset)
        else $error("reset pulse too long");
    gap_min_a: assert property (watchdog_reset |=> !watchdog_reset [*8])
        else $error("overflows too close");
    reset_cause_a: assert property (
        watchdog_reset |-> $past(watchdog_running, 24)) else $error("early reset");
    cover property (watchdog_reset);
    cover property ($rose(watchdog_running));
    cover property (sfr_rd && sfr_sel);
endmodule
bind wdt_top wdt_top_props u_props (
    .clk(clk), .reset_n(reset_n), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_rdata(sfr_rdata), .sfr_sel(sfr_sel),
    .option_auto_enable(option_auto_enable),
    .watchdog_reset(watchdog_reset), .watchdog_running(watchdog_running));
`default_nettype wire

// File: bench/wdt_top_test.sv
// Self-checking bench for the watchdog timer
`timescale 1ns/1ps
`default_nettype none
module wdt_top_test;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic idle = 1'b0;
    logic aci = 1'b0;
    logic [5:0] opt = 6'h00;
    logic [7:0] addr = 8'hE1;
    logic [7:0] wdata = 8'h00;
    wire logic [7:0] rdata;
    wire logic sel;
    wire logic wrst;
    wire logic run;
    int err_count = 0;
    int total_checks = 0;
    int n;
    always #2.5 clk = ~clk;
    wdt_top #(.CNT_WIDTH(2)) dut (
        .clk(clk), .reset_n(reset_n), .sfr_addr(addr), .sfr_wdata(wdata),
        .sfr_wr(wr), .sfr_rd(rd), .sfr_rdata(rdata), .sfr_sel(sel),
        .cpu_idle(idle), .option_auto_enable(opt[4]),
        .option_idle_count(opt[3]), .option_prescale_code(opt[2:0]),
        .option_write_protect(opt[5]), .option_always_count_idle(aci),
        .watchdog_reset(wrst), .watchdog_running(run));
    // Compare and bus tasks
    task automatic chk(input string s, input logic [15:0] e, logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", s, e, g);
        end
    endtask
    task automatic wrt(input logic [7:0] d);
        @(negedge clk);
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask
    task automatic rdc(input logic [7:0] e, input logic [7:0] a = 8'hE1);
        @(negedge clk);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        addr = 8'hE1;
        chk("rdata", {8'h00, e}, {8'h00, rdata});
    endtask
    // Cycles to the next overflow pulse, capped at lim
    task automatic pulse(input int lim);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (wrst !== 1'b1 && n < lim);
    endtask
    task automatic por(input logic [5:0] o);
        reset_n = 1'b0;
        opt = o;
        repeat (20) @(negedge clk);
        reset_n = 1'b1;
        @(negedge clk);
    endtask
    // Scenarios
    task automatic t_regs();
        rdc(8'h07);
        rdc(8'h00, 8'hE2);
        wrt(8'hDB);
        rdc(8'h0B);
        wrt(8'h20);
        wrt(8'h00);
        rdc(8'h20);
        chk("running", 16'h1, {15'h0, run});
    endtask
    task automatic t_period();
        for (int c = 0; c < 8; c++) begin
            wrt(8'h20 | 8'(c));
            pulse(30000);
            pulse(30000);
            chk("period", 16'(96 << c), 16'(n));
        end
        rdc(8'hA7);
        wrt(8'h20);
        rdc(8'h20);
    endtask
    task automatic t_clear_idle();
        repeat (6) begin
            wrt(8'h30);
            pulse(60);
            chk("cleared", 16'd60, 16'(n));
        end
        idle = 1'b1;
        pulse(400);
        chk("idle stop", 16'd400, 16'(n));
        aci = 1'b1;
        pulse(400);
        chk("always count", 16'h1, {15'h0, n < 400});
        aci = 1'b0;
        wrt(8'h28);
        pulse(400);
        chk("idle count", 16'h1, {15'h0, n < 400});
        idle = 1'b0;
    endtask
    task automatic t_option();
        por(6'h3D);
        rdc(8'h2D);
        wrt(8'h00);
        rdc(8'h2D);
    endtask
    task automatic final_report();
        if (err_count == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        #400000;
        err_count++;
        final_report();
    end
    initial begin
        por(6'h00);
        t_regs();
        t_period();
        t_clear_idle();
        t_option();
        final_report();
    end
endmodule
`default_nettype wire
